// [src/sdd_pkg.sv]
package sdd_pkg;
   // descriptor word 1 exception enables
   localparam int MASK_EXC_SRC_BIT   = 2;
   localparam int SW_EXC_SRC_BIT     = 1;
   localparam int MASK_EXC_CTL_BIT   = 11;
   localparam int SW_EXC_CTL_BIT     = 13;
   localparam int CTL_WORD_W         = 32;
   // descriptor word 2 scratch fields
   localparam int SCR_BASE_HI        = 31;
   localparam int SCR_BASE_LO        = 10;
   localparam int SCR_SIZE_HI        = 3;
   localparam int SCR_SIZE_LO        = 0;
   localparam logic [3:0] SCR_SIZE_MAX    = 4'hB;
   localparam logic [3:0] SCR_SIZE_BIG    = 4'hB;
   localparam int SCR_BYTES_W        = 22;
   localparam logic [21:0] SCR_UNIT_BYTES = 22'h000400;
   localparam logic [21:0] SCR_BIG_BYTES  = 22'h040000;
   // early-stepping control register bit that enables the big size
   localparam int EARLY_CTL_BIG_BIT  = 3;
   // descriptor word 3 constant read fields
   localparam int CONST_LEN_HI       = 30;
   localparam int CONST_LEN_LO       = 25;
   localparam int CONST_OFS_HI       = 23;
   localparam int CONST_OFS_LO       = 18;
   localparam int ADDR_W             = 32;
endpackage

// [src/sdd_scratch_size.sv]
`timescale 1ns/1ps
// per-thread scratch size decode, purely combinational
module sdd_scratch_size (
   // encoded field and mode
   input  wire logic [3:0]  size_code,
   input  wire logic        early_step,
   input  wire logic        big_enable,
   // decoded result
   output logic [21:0] size_bytes,
   output logic        size_legal
);
   always_comb begin
      size_legal = (size_code <= sdd_pkg::SCR_SIZE_MAX);
      if (!size_legal) begin
         size_bytes = '0;
      end else if (early_step) begin
         if (big_enable && size_code == sdd_pkg::SCR_SIZE_BIG) begin
            size_bytes = sdd_pkg::SCR_BIG_BYTES; // R6
         end else begin
            // linear steps on the early stepping
            size_bytes = 22'(sdd_pkg::SCR_UNIT_BYTES * (22'(size_code) + 22'h000001)); // R6
         end
      end else begin
         size_bytes = sdd_pkg::SCR_UNIT_BYTES << size_code; // R4
      end
   end
endmodule

// [src/sdd_decode.sv]
`timescale 1ns/1ps
// Function
// R1 - mask-stack enable bit 2 to control bit 11
// R2 - software exception bit 1 to control bit 13
// R3 - scratch offset plus general state base
// R4 - scratch size power of two, 1KB..2MB
// R5 - software reserves whole scratch region
// R6 - early stepping: linear sizes, value 11 big
// R7 - software aligns base 8MB for big size
// R8 - constant read length rows from bits 30:25
// R9 - constant read offset from bits 23:18
// R10 - zero length: no fetch, no rows
module sdd_decode (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        sys_rst,
   // descriptor words, valid for one cycle
   input  wire logic        desc_valid,
   input  wire logic [31:0] desc_word1,
   input  wire logic [31:0] desc_word2,
   input  wire logic [31:0] desc_word3,
   input  wire logic [31:0] general_state_base,
   // stepping straps and early control register bit field
   input  wire logic        early_step,
   input  wire logic [31:0] early_ctl,
   // core control word to the shader execution core
   output logic [31:0] core_control_word,
   // scratch region
   output logic [31:0] scratch_base_addr,
   output logic [21:0] scratch_bytes,
   output logic        scratch_size_legal,
   // constant return-buffer fetch
   output logic        const_fetch_req,
   output logic [5:0]  const_read_offset,
   output logic [5:0]  const_read_len,
   output logic [5:0]  payload_const_rows,
   // decode done strobe
   output logic        decode_valid
);

   // decoded descriptor fields
   logic        mask_exc_en;
   logic        sw_exc_en;
   logic [21:0] scr_base_field;
   logic [3:0]  scr_size_code;
   logic        big_enable;
   logic [5:0]  const_len_field;
   logic [5:0]  const_ofs_field;
   logic [31:0] scratch_ofs;
   logic        const_len_zero;
   // scratch size decoder results
   logic [21:0] size_bytes;
   logic        size_legal;
   // next register values
   logic [31:0] next_core_control_word;
   logic [31:0] next_scratch_base_addr;
   logic [21:0] next_scratch_bytes;
   logic        next_scratch_size_legal;
   logic        next_const_fetch_req;
   logic [5:0]  next_const_read_offset;
   logic [5:0]  next_const_read_len;
   logic [5:0]  next_payload_const_rows;
   logic        next_decode_valid;

   // field extraction; no state, every output group except the done strobe reads from here
   always_comb begin
      mask_exc_en     = desc_word1[sdd_pkg::MASK_EXC_SRC_BIT]; // R1
      sw_exc_en       = desc_word1[sdd_pkg::SW_EXC_SRC_BIT]; // R2
      scr_base_field  = desc_word2[sdd_pkg::SCR_BASE_HI:sdd_pkg::SCR_BASE_LO]; // R3
      scr_size_code   = desc_word2[sdd_pkg::SCR_SIZE_HI:sdd_pkg::SCR_SIZE_LO]; // R4
      // the big-size enable only matters on the early stepping
      big_enable      = early_ctl[sdd_pkg::EARLY_CTL_BIG_BIT]; // R6
      const_len_field = desc_word3[sdd_pkg::CONST_LEN_HI:sdd_pkg::CONST_LEN_LO]; // R8
      const_ofs_field = desc_word3[sdd_pkg::CONST_OFS_HI:sdd_pkg::CONST_OFS_LO]; // R9
      // low bits forced to zero: the offset is always 1KB aligned
      scratch_ofs     = {scr_base_field, {sdd_pkg::SCR_BASE_LO{1'b0}}}; // R3
      const_len_zero  = (const_len_field == 6'h00); // R10
   end

   // size decode kept apart so the stepping quirk lives in one place
   sdd_scratch_size u_size (
      .size_code  (scr_size_code),
      .early_step (early_step),
      .big_enable (big_enable),
      .size_bytes (size_bytes),
      .size_legal (size_legal)
   );

   // control word: only the two exception enables are carried
   always_comb begin
      next_core_control_word = core_control_word;
      if (desc_valid) begin
         // the rest stays clear so an old enable never leaks into a new thread
         next_core_control_word = '0;
         // source and destination bit numbers differ on purpose
         next_core_control_word[sdd_pkg::MASK_EXC_CTL_BIT] = mask_exc_en; // R1
         next_core_control_word[sdd_pkg::SW_EXC_CTL_BIT]   = sw_exc_en; // R2
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         core_control_word <= '0;
      end else begin
         core_control_word <= next_core_control_word;
      end
   end

   // scratch base: carry past bit 31 is dropped, software keeps the region in range
   always_comb begin
      next_scratch_base_addr = scratch_base_addr;
      if (desc_valid) begin
         next_scratch_base_addr = 32'(general_state_base + scratch_ofs); // R3
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         scratch_base_addr <= '0;
      end else begin
         scratch_base_addr <= next_scratch_base_addr;
      end
   end

   // scratch size: a code above the range reads as zero bytes and not legal
   always_comb begin
      next_scratch_bytes      = scratch_bytes;
      next_scratch_size_legal = scratch_size_legal;
      if (desc_valid) begin
         next_scratch_bytes      = size_bytes; // R4
         next_scratch_size_legal = size_legal; // R4
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         scratch_bytes      <= '0;
         scratch_size_legal <= 1'b0;
      end else begin
         scratch_bytes      <= next_scratch_bytes;
         scratch_size_legal <= next_scratch_size_legal;
      end
   end

   // constant read offset, in 256-bit rows
   always_comb begin
      next_const_read_offset = const_read_offset;
      if (desc_valid) begin
         next_const_read_offset = const_ofs_field; // R9
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         const_read_offset <= '0;
      end else begin
         const_read_offset <= next_const_read_offset;
      end
   end

   // constant read length, in 256-bit rows
   always_comb begin
      next_const_read_len = const_read_len;
      if (desc_valid) begin
         next_const_read_len = const_len_field; // R8
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         const_read_len <= '0;
      end else begin
         const_read_len <= next_const_read_len;
      end
   end

   // rows added to the payload; none when the length is zero
   always_comb begin
      next_payload_const_rows = payload_const_rows;
      if (desc_valid) begin
         if (const_len_zero) begin
            next_payload_const_rows = 6'h00; // R10
         end else begin
            next_payload_const_rows = const_len_field; // R8
         end
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         payload_const_rows <= '0;
      end else begin
         payload_const_rows <= next_payload_const_rows;
      end
   end

   // fetch request: a one-cycle pulse, never raised for a zero length
   // request and row count share one compare so they cannot disagree
   always_comb begin
      next_const_fetch_req = 1'b0;
      if (desc_valid) begin
         next_const_fetch_req = !const_len_zero; // R10
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         const_fetch_req <= 1'b0;
      end else begin
         const_fetch_req <= next_const_fetch_req;
      end
   end

   // done strobe: one cycle after each accepted descriptor, back to back allowed
   always_comb begin
      next_decode_valid = desc_valid;
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         decode_valid <= 1'b0;
      end else begin
         decode_valid <= next_decode_valid;
      end
   end
endmodule

// [tb/sdd_decode_asserts.sv]
`timescale 1ns/1ps
module sdd_decode_asserts (
   // clock and reset
   input wire logic        clk,
   input wire logic        sys_rst,
   // descriptor side
   input wire logic        desc_valid,
   input wire logic [31:0] desc_word1,
   input wire logic [31:0] desc_word2,
   input wire logic [31:0] desc_word3,
   input wire logic [31:0] general_state_base,
   input wire logic        early_step,
   input wire logic [31:0] early_ctl,
   // decoded outputs
   input wire logic [31:0] core_control_word,
   input wire logic [31:0] scratch_base_addr,
   input wire logic [21:0] scratch_bytes,
   input wire logic        scratch_size_legal,
   input wire logic        const_fetch_req,
   input wire logic [5:0]  const_read_offset,
   input wire logic [5:0]  const_read_len,
   input wire logic [5:0]  payload_const_rows,
   input wire logic        decode_valid
);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   property p_done; desc_valid |=> decode_valid; endproperty
   a_done: assert property (p_done) else $error("done");
   property p_mask; desc_valid |=> core_control_word[11] == $past(desc_word1[2]); endproperty
   a_mask: assert property (p_mask) else $error("mask");
   property p_sw; desc_valid |=> core_control_word[13] == $past(desc_word1[1]); endproperty
   a_sw: assert property (p_sw) else $error("sw");
   property p_len; desc_valid |=> const_read_len == $past(desc_word3[30:25]); endproperty
   a_len: assert property (p_len) else $error("len");
   property p_ofs; desc_valid |=> const_read_offset == $past(desc_word3[23:18]); endproperty
   a_ofs: assert property (p_ofs) else $error("ofs");
   property p_fetch; desc_valid |=> const_fetch_req == ($past(desc_word3[30:25]) != 6'h00);
   endproperty
   a_fetch: assert property (p_fetch) else $error("fetch");
   property p_rows; desc_valid |=> payload_const_rows == $past(desc_word3[30:25]); endproperty
   a_rows: assert property (p_rows) else $error("rows");
   property p_size; desc_valid && !early_step && desc_word2[3:0] <= 4'hB
      |=> scratch_bytes == 22'h000400 << $past(desc_word2[3:0]); endproperty
   a_size: assert property (p_size) else $error("size");
   property p_base; desc_valid |=> scratch_base_addr ==
      $past(general_state_base) + {$past(desc_word2[31:10]), 10'h000}; endproperty
   a_base: assert property (p_base) else $error("base");
   property p_legal; desc_valid |=> scratch_size_legal == ($past(desc_word2[3:0]) <= 4'hB);
   endproperty
   a_legal: assert property (p_legal) else $error("legal");
   property p_early; desc_valid && early_step && desc_word2[3:0] <= 4'hB
      |=> scratch_bytes == (($past(early_ctl[3]) && $past(desc_word2[3:0]) == 4'hB) ?
      22'h040000 : 22'h000400 * ($past(desc_word2[3:0]) + 22'h000001)); endproperty
   a_early: assert property (p_early) else $error("early size");
   property p_pulse; const_fetch_req |-> decode_valid; endproperty
   a_pulse: assert property (p_pulse) else $error("fetch pulse");
   property p_hold; !desc_valid |=> $stable(core_control_word) && $stable(scratch_base_addr)
      && $stable(scratch_bytes) && $stable(const_read_offset) && $stable(const_read_len)
      && $stable(payload_const_rows); endproperty
   a_hold: assert property (p_hold) else $error("hold");
endmodule
bind sdd_decode sdd_decode_asserts chk (
   .clk                (clk),
   .sys_rst            (sys_rst),
   .desc_valid         (desc_valid),
   .desc_word1         (desc_word1),
   .desc_word2         (desc_word2),
   .desc_word3         (desc_word3),
   .general_state_base (general_state_base),
   .early_step         (early_step),
   .early_ctl          (early_ctl),
   .core_control_word  (core_control_word),
   .scratch_base_addr  (scratch_base_addr),
   .scratch_bytes      (scratch_bytes),
   .scratch_size_legal (scratch_size_legal),
   .const_fetch_req    (const_fetch_req),
   .const_read_offset  (const_read_offset),
   .const_read_len     (const_read_len),
   .payload_const_rows (payload_const_rows),
   .decode_valid       (decode_valid)
);

// [tb/sdd_desc_mem.sv]
`timescale 1ns/1ps
// descriptor memory as software leaves it, must_be_zero bits clear
module sdd_desc_mem (
   input  wire logic [31:0] raw1, raw2, raw3, early_ctl,
   input  wire logic        early_step,
   output logic [31:0]      desc_word1, desc_word2, desc_word3
);
   always_comb begin
      desc_word1 = raw1 & 32'h0000_0006;
      desc_word2 = raw2 & 32'hFFFF_FC0F;
      if (early_step && early_ctl[3] && raw2[3:0] == 4'hB) desc_word2[22:10] = 13'h0;
      desc_word3 = raw3 & 32'h7EFC_0000;
   end
endmodule

// [tb/shader_dispatch_state_decode_bench.sv]
`timescale 1ns/1ps
module shader_dispatch_state_decode_bench;
   logic         clk, sys_rst, desc_valid, early_step, decode_valid, const_fetch_req;
   logic         scratch_size_legal;
   logic [31:0]  raw1, raw2, raw3, desc_word1, desc_word2, desc_word3, early_ctl;
   logic [31:0]  general_state_base, core_control_word, scratch_base_addr;
   logic [21:0]  scratch_bytes;
   logic [5:0]   const_read_offset, const_read_len, payload_const_rows;
   logic [105:0] exp_q[$], x;
   int           err_total, samples_checked, seed = 32'h7BB8;
   sdd_desc_mem mem (
      .raw1       (raw1),
      .raw2       (raw2),
      .raw3       (raw3),
      .early_ctl  (early_ctl),
      .early_step (early_step),
      .desc_word1 (desc_word1),
      .desc_word2 (desc_word2),
      .desc_word3 (desc_word3)
   );
   sdd_decode uut (
      .clk                (clk),
      .sys_rst            (sys_rst),
      .desc_valid         (desc_valid),
      .desc_word1         (desc_word1),
      .desc_word2         (desc_word2),
      .desc_word3         (desc_word3),
      .general_state_base (general_state_base),
      .early_step         (early_step),
      .early_ctl          (early_ctl),
      .core_control_word  (core_control_word),
      .scratch_base_addr  (scratch_base_addr),
      .scratch_bytes      (scratch_bytes),
      .scratch_size_legal (scratch_size_legal),
      .const_fetch_req    (const_fetch_req),
      .const_read_offset  (const_read_offset),
      .const_read_len     (const_read_len),
      .payload_const_rows (payload_const_rows),
      .decode_valid       (decode_valid)
   );
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   task automatic check(string n, logic [63:0] s, e);
      samples_checked++;
      if (s !== e) begin err_total++; $display("[FAIL] %s exp %h got %h", n, e, s); end
   endtask
   // every output must read zero right after a reset
   task automatic check_cleared;
      check("rst flags", {decode_valid, const_fetch_req, scratch_size_legal}, 64'h0);
      check("rst ctl", core_control_word, 64'h0);
      check("rst scratch", {scratch_base_addr, scratch_bytes}, 64'h0);
      check("rst const", {const_read_offset, const_read_len, payload_const_rows}, 64'h0);
   endtask
   function automatic logic [21:0] sz(logic [3:0] c);
      if (c > 4'hB) return 22'h0;
      if (!early_step) return 22'h000400 << c;
      if (c == 4'hB && early_ctl[3]) return 22'h040000;
      return 22'h000400 * (c + 1);
   endfunction
   always @(negedge clk) if (!sys_rst && decode_valid !== 1'b0) begin
      x = exp_q.size() ? exp_q.pop_front() : '1;
      check("ctl", core_control_word, x[105:74]);
      check("base", scratch_base_addr, x[73:42]);
      check("size", {scratch_bytes, scratch_size_legal}, x[41:19]);
      check("fetch", {const_fetch_req, payload_const_rows}, x[18:12]);
      check("len", const_read_len, x[11:6]);
      check("ofs", const_read_offset, x[5:0]);
   end
   task final_report;
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      sys_rst = 1;
      {desc_valid, early_step, raw1, raw2, raw3, general_state_base, early_ctl} = '0;
      repeat (10) @(negedge clk);
      sys_rst = 1'b0;
      check_cleared();
      $display("reset test done");
      // every size code, zero lengths and gaps mixed into back-to-back traffic
      for (int i = 0; i < 400; i++) begin
         if (i == 200) begin
            // mid-run reset once the last result has been checked
            desc_valid = 1'b0;
            @(negedge clk);
            sys_rst = 1'b1;
            repeat (3) @(negedge clk);
            sys_rst = 1'b0;
            check_cleared();
            $display("mid-run reset test done");
         end
         raw1 = $random(seed);
         raw2 = ($random(seed) & 32'hFFFF_FFF0) | i[3:0];
         raw3 = $random(seed) & (i % 7 ? 32'hFFFF_FFFF : 32'h81FF_FFFF);
         general_state_base = $random(seed);
         early_ctl = $random(seed);
         early_step = i[4];
         desc_valid = i % 5 != 0;
         #1 if (desc_valid) exp_q.push_back({18'h0, desc_word1[1], 1'b0, desc_word1[2], 11'h0,
            general_state_base + {desc_word2[31:10], 10'h000}, sz(desc_word2[3:0]),
            desc_word2[3:0] <= 4'hB, desc_word3[30:25] != 6'h00, desc_word3[30:25],
            desc_word3[30:25], desc_word3[23:18]});
         @(negedge clk);
      end
      desc_valid = 0;
      for (int k = 0; k < 4 && exp_q.size() > 0; k++) @(negedge clk);
      if (exp_q.size() > 0) err_total++;
      $display("random test done");
      final_report;
   end
endmodule
